// File: hw/rssc_defs.vh
`ifndef RSSC_DEFS_VH
`define RSSC_DEFS_VH
// ==========================================================
// Start-up timing
`define RSSC_STARTUP_CYCLES   11'h400
`define RSSC_STARTUP_WIDTH    11
// ==========================================================
// Reset values of the reset-loaded registers
`define RSSC_PC_RESET         12'h000
`define RSSC_WDSEL_RESET      8'h87
`define RSSC_PORT_RESET       8'hFF
`define RSSC_INTC_RESET       7'h00
// ==========================================================
// Reset cause codes (timeout_flag, powerdown_flag as reported)
`define RSSC_CAUSE_NONE       3'h0
`define RSSC_CAUSE_POWERUP    3'h1
`define RSSC_CAUSE_PIN_RUN    3'h2
`define RSSC_CAUSE_PIN_HALT   3'h3
`define RSSC_CAUSE_WDT_RUN    3'h4
`define RSSC_CAUSE_WDT_HALT   3'h5
`endif

// File: hw/rssc_sync.v
// ==========================================================
// Two-stage synchroniser for one level
module rssc_sync (
  input  wire I_CLK,
  input  wire I_RESET,
  input  wire i_d,
  output wire o_q
);
  reg meta_ff;  // First stage, read only by second stage
  reg q_ff;     // Second stage, safe to use

  // Resets to 1 so the active-low pin reads idle after reset
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      meta_ff <= 1'b1;
      q_ff    <= 1'b1;
    end else begin
      meta_ff <= i_d;
      q_ff    <= meta_ff;
    end
  end

  assign o_q = q_ff;
endmodule

// File: hw/rssc_top.v
// Contract
// - Three full causes: pin run, pin halt, watchdog run
// - Watchdog in halt resets only PC and SP
// - Power-up clears flags; pin flags per condition
// - Watchdog sets timeout; in halt both flags
// - Start-up delay of 1024 clocks after resets
// - Internal reset held until the delay completes
// - Chip reset: PC zero, ints off, ports input
// - Non-warm reset loads initial register values
// - Halt sets powerdown flag; power-up or clear clears
`include "rssc_defs.vh"
module rssc_top #(
  parameter STARTUP_CYCLES = `RSSC_STARTUP_CYCLES
) (
  input  wire       I_CLK,
  input  wire       I_RESET,
  input  wire       I_EXT_RESET_N,
  input  wire       I_WDT_TIMEOUT,
  input  wire       I_HALT_EXEC,
  input  wire       I_WDT_CLEAR_EXEC,
  input  wire       I_WAKE_OTHER,
  output reg        O_CORE_RESET,
  output reg        O_WARM_RESET,
  output reg        O_STALL,
  output reg        O_HALTED,
  output reg        O_TIMEOUT_FLAG,
  output reg        O_POWERDOWN_FLAG,
  output reg  [11:0] O_PC_INIT,
  output reg        O_INT_DISABLE,
  output reg        O_WDT_CLEAR,
  output reg        O_TIMERS_OFF,
  output reg        O_PORTS_INPUT,
  output reg        O_SP_TOP,
  output reg  [7:0] O_WDSEL_INIT,
  output reg  [7:0] O_PORT_INIT
);
  // ==========================================================
  // Local state
  localparam ST_POWERUP = 2'h0;  // Power-on start-up delay
  localparam ST_RUN     = 2'h1;  // Normal operation
  localparam ST_HALT    = 2'h2;  // Power-down, clock assumed gated outside
  localparam ST_DELAY   = 2'h3;  // Start-up delay after reset or wake

  wire        ext_reset_n_s;     // Synchronised pin level
  reg  [1:0]  state_ff;          // Sequencer state
  reg  [1:0]  nxt_state;
  reg  [10:0] cnt_ff;            // Start-up delay counter
  reg  [10:0] nxt_cnt;
  reg         hold_reset_ff;     // Delay belongs to a reset (not a plain wake)
  reg         nxt_hold_reset;
  reg         warm_ff;           // Delay follows a warm reset
  reg         nxt_warm;
  reg         to_ff;             // timeout_flag
  reg         nxt_to;
  reg         pd_ff;             // powerdown_flag
  reg         nxt_pd;

  // Last count of the delay; the counter is 11 bits, so the full-width
  // value is cut on purpose. Delays above 2048 clocks need a wider counter.
  localparam [31:0] DELAY_LAST_W = STARTUP_CYCLES - 1;  // Full-width last count
  localparam [10:0] DELAY_LAST   = DELAY_LAST_W[10:0];  // Counter-width last count

  // ==========================================================
  // Pin synchroniser
  rssc_sync u_sync (
    .I_CLK   (I_CLK),
    .I_RESET (I_RESET),
    .i_d     (I_EXT_RESET_N),
    .o_q     (ext_reset_n_s)
  );

  // ==========================================================
  // Next-state and flag logic
  // Causes are ranked pin, then watchdog, then halt, then clear,
  // so a pin reset always wins over anything the core asks for.
  // Requests that arrive during the delay are dropped on purpose:
  // the core is not running then, so it cannot have issued them.
  // A watchdog event and a clear in the same cycle leave the flag
  // set, as the event is ranked first.
  // The pin restarts the count while it is held low, so the delay
  // is always measured from the release of the pin.
  always @* begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_hold_reset = hold_reset_ff;
    nxt_warm       = warm_ff;
    nxt_to         = to_ff;
    nxt_pd         = pd_ff;
    case (state_ff)
      ST_POWERUP, ST_DELAY: begin
        // Pin held low restarts the delay so it ends after release
        if (!ext_reset_n_s) begin
          nxt_cnt        = 11'h000;
          nxt_hold_reset = 1'b1;
          nxt_warm       = 1'b0;
        end else if (cnt_ff == DELAY_LAST) begin
          nxt_state = ST_RUN;
          nxt_cnt   = 11'h000;
        end else begin
          nxt_cnt = cnt_ff + 11'h001;
        end
      end
      ST_RUN: begin
        if (!ext_reset_n_s) begin
          // Pin reset in run: flags unchanged
          nxt_state      = ST_DELAY;
          nxt_hold_reset = 1'b1;
          nxt_warm       = 1'b0;
        end else if (I_WDT_TIMEOUT) begin
          nxt_state      = ST_DELAY;
          nxt_hold_reset = 1'b1;
          nxt_warm       = 1'b0;
          nxt_to         = 1'b1;
        end else if (I_HALT_EXEC) begin
          nxt_state = ST_HALT;
          nxt_pd    = 1'b1;
          nxt_to    = 1'b0;
        end else if (I_WDT_CLEAR_EXEC) begin
          nxt_pd = 1'b0;
          nxt_to = 1'b0;
        end
      end
      ST_HALT: begin
        if (!ext_reset_n_s) begin
          nxt_state      = ST_DELAY;
          nxt_hold_reset = 1'b1;
          nxt_warm       = 1'b0;
          nxt_to         = 1'b0;
          nxt_pd         = 1'b1;
        end else if (I_WDT_TIMEOUT) begin
          // Warm reset: only PC and SP return to start
          nxt_state      = ST_DELAY;
          nxt_hold_reset = 1'b1;
          nxt_warm       = 1'b1;
          nxt_to         = 1'b1;
          nxt_pd         = 1'b1;
        end else if (I_WAKE_OTHER) begin
          // Plain wake still waits, but the core is only stalled
          nxt_state      = ST_DELAY;
          nxt_hold_reset = 1'b0;
          nxt_warm       = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_POWERUP;
      end
    endcase
  end

  // ==========================================================
  // State registers; power-up clears both flags
  // The power-on reset starts in the power-up state with the full
  // reset applied, so the core never runs before the delay ends.
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_ff      <= ST_POWERUP;
      cnt_ff        <= 11'h000;
      hold_reset_ff <= 1'b1;
      warm_ff       <= 1'b0;
      to_ff         <= 1'b0;
      pd_ff         <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      hold_reset_ff <= nxt_hold_reset;
      warm_ff       <= nxt_warm;
      to_ff         <= nxt_to;
      pd_ff         <= nxt_pd;
    end
  end

  // ==========================================================
  // Registered outputs, decoded from the next state so that
  // they line up with the state register
  // Decoding from the next state costs a longer path into the
  // output flops but avoids a one-cycle lag behind the state.
  // The warm case keeps every register value except PC and SP,
  // so the chip-reset actions are held low during it.
  // A plain wake only stalls the core; no reset line rises then.
  wire in_delay   = (nxt_state == ST_DELAY) || (nxt_state == ST_POWERUP);
  wire full_reset = in_delay && nxt_hold_reset && !nxt_warm;

  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CORE_RESET     <= 1'b1;
      O_WARM_RESET     <= 1'b0;
      O_STALL          <= 1'b1;
      O_HALTED         <= 1'b0;
      O_TIMEOUT_FLAG   <= 1'b0;
      O_POWERDOWN_FLAG <= 1'b0;
      O_PC_INIT        <= `RSSC_PC_RESET;
      O_INT_DISABLE    <= 1'b1;
      O_WDT_CLEAR      <= 1'b1;
      O_TIMERS_OFF     <= 1'b1;
      O_PORTS_INPUT    <= 1'b1;
      O_SP_TOP         <= 1'b1;
      O_WDSEL_INIT     <= `RSSC_WDSEL_RESET;
      O_PORT_INIT      <= `RSSC_PORT_RESET;
    end else begin
      // Reset stays applied across the whole delay
      O_CORE_RESET     <= full_reset;
      O_WARM_RESET     <= in_delay && nxt_warm;
      O_STALL          <= in_delay;
      O_HALTED         <= (nxt_state == ST_HALT);
      O_TIMEOUT_FLAG   <= nxt_to;
      O_POWERDOWN_FLAG <= nxt_pd;
      O_PC_INIT        <= `RSSC_PC_RESET;
      // Chip-reset actions skip the warm case
      O_INT_DISABLE    <= full_reset;
      O_WDT_CLEAR      <= full_reset;
      O_TIMERS_OFF     <= full_reset;
      O_PORTS_INPUT    <= full_reset;
      O_SP_TOP         <= in_delay && nxt_hold_reset;
      O_WDSEL_INIT     <= `RSSC_WDSEL_RESET;
      O_PORT_INIT      <= `RSSC_PORT_RESET;
    end
  end
endmodule

// File: test/rssc_props.sv
module rssc_props #(parameter STARTUP_CYCLES = 8) (
  input wire        I_CLK,
  input wire        I_RESET,
  input wire        I_EXT_RESET_N,
  input wire        I_WDT_TIMEOUT,
  input wire        I_HALT_EXEC,
  input wire        I_WDT_CLEAR_EXEC,
  input wire        I_WAKE_OTHER,
  input wire        O_CORE_RESET,
  input wire        O_WARM_RESET,
  input wire        O_STALL,
  input wire        O_HALTED,
  input wire        O_TIMEOUT_FLAG,
  input wire        O_POWERDOWN_FLAG,
  input wire [11:0] O_PC_INIT,
  input wire [7:0]  O_WDSEL_INIT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // ==================================================
  // Helpers: stall length and pin history
  int       stall_cnt_ff;  // Consecutive stall cycles
  logic [1:0] pin_ff;      // Pin was high in the last two cycles
  wire run    = !O_STALL && !O_HALTED && !O_CORE_RESET;
  wire pin_ok = I_EXT_RESET_N && (&pin_ff);  // Sync cannot still carry a low
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      stall_cnt_ff <= 0;
      pin_ff       <= 2'h3;
    end else begin
      stall_cnt_ff <= O_STALL ? stall_cnt_ff + 1 : 0;
      pin_ff       <= {pin_ff[0], I_EXT_RESET_N};
    end
  end
  // Pin held low for three samples with no competing cause
  sequence s_pin_low;
    (!I_EXT_RESET_N && !I_WDT_TIMEOUT && !I_WAKE_OTHER) [*3];
  endsequence
  // ==================================================
  // Properties
  AST_PIN_RUN: assert property (run ##0 s_pin_low |-> ##[1:2] O_CORE_RESET)
    else $error("pin reset in run not applied");
  AST_PIN_HALT: assert property (O_HALTED && !O_STALL ##0 s_pin_low |-> ##[1:2]
    (O_CORE_RESET && !O_TIMEOUT_FLAG && O_POWERDOWN_FLAG)) else $error("pin wake flags wrong");
  AST_WDT_RUN: assert property (run && pin_ok && I_WDT_TIMEOUT |=>
    O_CORE_RESET && O_TIMEOUT_FLAG && $stable(O_POWERDOWN_FLAG)) else $error("wdt run wrong");
  AST_WDT_HALT: assert property (O_HALTED && !O_STALL && pin_ok && I_WDT_TIMEOUT |=>
    O_WARM_RESET && !O_CORE_RESET && O_TIMEOUT_FLAG && O_POWERDOWN_FLAG)
    else $error("wdt halt not warm");
  AST_HALT: assert property (run && pin_ok && !I_WDT_TIMEOUT && I_HALT_EXEC |=>
    O_HALTED && O_POWERDOWN_FLAG && !O_TIMEOUT_FLAG) else $error("halt flags wrong");
  AST_CLEAR: assert property (run && pin_ok && !I_WDT_TIMEOUT && !I_HALT_EXEC &&
    I_WDT_CLEAR_EXEC |=> !O_POWERDOWN_FLAG) else $error("clear kept powerdown flag");
  AST_WAKE: assert property (O_HALTED && !O_STALL && pin_ok && !I_WDT_TIMEOUT &&
    I_WAKE_OTHER |=> O_STALL && !O_CORE_RESET && !O_WARM_RESET) else $error("wake wrong");
  AST_CHIP: assert property (O_CORE_RESET |-> O_STALL && O_PC_INIT == 12'h000 &&
    O_WDSEL_INIT == 8'h87) else $error("chip reset values wrong");
  AST_STALL_MIN: assert property ($fell(O_STALL) |-> $past(stall_cnt_ff) >= STARTUP_CYCLES - 1)
    else $error("start-up delay too short");
  AST_WARM_MAX: assert property (O_WARM_RESET |-> stall_cnt_ff <= STARTUP_CYCLES + 1)
    else $error("warm reset too long");
endmodule

bind rssc_top rssc_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) rssc_props_inst (.*);

// File: test/rssc_top_tb.sv
module rssc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 8;  // Short start-up delay keeps the run brief
  logic clk = 0, rst = 1, pin = 1;
  logic [3:0] ev = 4'h0;  // Timeout, halt, clear, wake
  int mismatches = 0, tests_run = 0, n_stall;
  wire core, warm, stall, halted, to_f, pd_f;
  wire [11:0] pc;
  wire [7:0] wds, port;
  wire [4:0] act;  // Int off, watchdog clear, timers off, ports input, SP top
  rssc_top #(.STARTUP_CYCLES(N)) rssc_top_inst (.I_CLK(clk), .I_RESET(rst),
    .I_EXT_RESET_N(pin), .I_WDT_TIMEOUT(ev[0]), .I_HALT_EXEC(ev[1]),
    .I_WDT_CLEAR_EXEC(ev[2]), .I_WAKE_OTHER(ev[3]), .O_CORE_RESET(core),
    .O_WARM_RESET(warm), .O_STALL(stall), .O_HALTED(halted), .O_TIMEOUT_FLAG(to_f),
    .O_POWERDOWN_FLAG(pd_f), .O_PC_INIT(pc), .O_INT_DISABLE(act[4]), .O_WDT_CLEAR(act[3]),
    .O_TIMERS_OFF(act[2]), .O_PORTS_INPUT(act[1]), .O_SP_TOP(act[0]),
    .O_WDSEL_INIT(wds), .O_PORT_INIT(port));
  // ==================================================
  // Clock and hang guard
  initial forever #25 clk = ~clk;
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    conclude();
  end
  task check(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude();
    $display("%0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One-cycle request, then look once the design has taken it
  task pulse(int b);
    @(posedge clk) ev[b] <= 1'b1;
    @(posedge clk) ev <= 4'h0;
    #1;
  endtask
  // Bounded wait for the start-up delay to end
  task run_wait();
    n_stall = 0;
    while (stall === 1'b1 && n_stall < 200) begin
      @(posedge clk);
      #1 n_stall++;
    end
    check(stall, 0);
  endtask
  // Pin low long enough to pass the synchroniser
  task pin_low(logic [1:0] flags);
    @(posedge clk) pin <= 1'b0;
    repeat (5) @(posedge clk);
    #1 check(core, 1);
    check({to_f, pd_f}, flags);
    @(posedge clk) pin <= 1'b1;
    run_wait();
  endtask
  // ==================================================
  // Scenarios
  task t_power();
    repeat (19) @(posedge clk);
    #1 check({core, stall, pc, wds, port}, {2'h3, 12'h000, 8'h87, 8'hFF});
    check(act, 5'h1F);
    @(posedge clk) rst <= 1'b0;
    #1 run_wait();
    check({to_f, pd_f}, 2'h0);
    $display("test power done");
  endtask
  task t_wdt_halt();
    pulse(0);
    check({core, to_f, pd_f}, 3'h6);
    check(act, 5'h1F);
    run_wait();
    pulse(1);
    check({halted, to_f, pd_f}, 3'h5);
    pulse(0);
    check({warm, core, to_f, pd_f}, 4'hB);
    check(act, 5'h01);
    run_wait();
    $display("test watchdog done");
  endtask
  task t_pin();
    pin_low(2'h3);
    pulse(2);
    check({to_f, pd_f}, 2'h0);
    pulse(1);
    pin_low(2'h1);
    $display("test pin done");
  endtask
  task t_wake();
    pulse(1);
    pulse(3);
    check({stall, core, warm}, 3'h4);
    check(act, 5'h00);
    run_wait();
    check(n_stall >= N - 1 && n_stall <= N + 1, 1);
    $display("test wake done");
  endtask
  initial begin
    t_power();
    t_wdt_halt();
    t_pin();
    t_wake();
    conclude();
  end
endmodule
